// ===== rtl/pilot_sup_pkg.sv
package pilot_sup_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned TICK_MS     = 100;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // Supervision timing in milliseconds
  localparam int unsigned START_MS = 2000;
  localparam int unsigned PULSE_MS = 1000;
  localparam int unsigned DWELL_MS = 500;
  localparam int unsigned HOLD_MS  = 2000;

  // Same timing in ticks
  localparam logic [5:0] START_TICKS = 6'(START_MS / TICK_MS);
  localparam logic [5:0] PULSE_TICKS = 6'(PULSE_MS / TICK_MS);
  localparam logic [5:0] CYCLE_TICKS = 6'(4 * PULSE_MS / TICK_MS);
  localparam logic [5:0] GAP_END     = 6'(2 * PULSE_MS / TICK_MS - 1);
  localparam logic [5:0] SAMPLE_PH   = 6'(5 * PULSE_MS / TICK_MS / 2);
  localparam logic [5:0] LOCK_MIN    = 6'(PULSE_MS / TICK_MS - 2);
  localparam logic [5:0] HOLD_TICKS  = 6'(HOLD_MS / TICK_MS);
  localparam logic [2:0] DWELL_TICKS = 3'(DWELL_MS / TICK_MS);

  // Alarm counts in supervision cycles
  localparam logic [1:0] MISS_LIMIT = 2'h3;
  localparam logic [1:0] GOOD_LIMIT = 2'h2;

  // Register map, byte addresses
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] DELAY_OFS  = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;

  // Field positions and reset values
  localparam int unsigned MODE_POS    = 0;
  localparam int unsigned DISCRIMINATION_DELAY_SETTING_POS    = 0;
  localparam int unsigned ST_HEALTHY  = 0;
  localparam int unsigned ST_ALARM    = 1;
  localparam int unsigned ST_TRIPOPEN = 2;
  localparam int unsigned ST_DISC     = 3;
  localparam int unsigned ST_LOCK     = 4;
  localparam int unsigned ST_MISS     = 8;
  localparam int unsigned ST_FSM      = 12;
  localparam int unsigned ST_PHASE    = 16;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [4:0] DISCRIMINATION_DELAY_SETTING_RST = 5'h01;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_OFF    = 2'h0,
    MODE_MASTER = 2'h1,
    MODE_SLAVE  = 2'h2
  } mode_t;

  typedef enum logic [2:0] {
    ST_OFF   = 3'h1,
    ST_START = 3'h2,
    ST_RUN   = 3'h4
  } sup_state_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;

  typedef struct packed {
    logic pilot_sense;
    logic reset_btn;
    logic initiate;
    logic trip_in;
  } pins_in_t;

  typedef struct packed {
    logic pilot_drive;
    logic healthy_led;
    logic alarm_led;
    logic alarm_contact;
    logic trip_out;
    logic disc_led;
    logic activity_led;
  } pins_out_t;

endpackage : pilot_sup_pkg

// ===== rtl/tick_gen.sv
`timescale 1ns/1ns
module tick_gen #(
  parameter int unsigned CYCLES = 2
) (
  // Clock and reset
  input  logic clk,
  input  logic rstn,
  // Time base
  output logic tick
);

  localparam int unsigned CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } tick_st_t;

  tick_st_t r_reg;
  tick_st_t r_next;

  always_comb begin
    r_next = r_reg;
    r_next.tick = 1'b0;
    if (r_reg.cnt == CW'(CYCLES - 1)) begin
      r_next.cnt  = '0;
      r_next.tick = 1'b1;
    end else begin
      r_next.cnt = r_reg.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign tick = r_reg.tick;

endmodule : tick_gen

// ===== rtl/pilot_sup.sv
`timescale 1ns/1ns
module pilot_sup #(
  parameter int unsigned TICK_CYCLES = pilot_sup_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  logic                      clk,
  input  logic                      rstn,
  // Register bus
  input  pilot_sup_pkg::axi_req_t   axi_req,
  output pilot_sup_pkg::axi_rsp_t   axi_rsp,
  // Pilot, panel and trip pins
  input  pilot_sup_pkg::pins_in_t   pins_in,
  output pilot_sup_pkg::pins_out_t  pins_out
);

  typedef struct packed {
    pilot_sup_pkg::pins_in_t   sync1;
    pilot_sup_pkg::pins_in_t   sync2;
    pilot_sup_pkg::sup_state_t st;
    logic [5:0]                phase;
    logic [5:0]                run;
    logic [5:0]                hold;
    logic                      lock;
    logic                      got;
    logic                      ok;
    logic [1:0]                miss;
    logic [1:0]                good;
    logic                      alarm;
    logic [2:0]                dwell;
    logic                      trip_open;
    logic                      done;
    logic [4:0]                disc;
    logic [1:0]                mode;
    logic [4:0]                discrimination_delay_setting;
    logic                      aw_ok;
    logic [7:0]                awaddr;
    logic                      w_ok;
    logic [31:0]               wdata;
    logic [3:0]                wstrb;
    pilot_sup_pkg::pins_out_t  po;
    pilot_sup_pkg::axi_rsp_t   rsp;
  } sup_st_t;

  sup_st_t r_reg;
  sup_st_t r_next;
  logic    tick;
  logic    sense;
  logic    rst_in;
  logic    init_in;
  logic    trip_in;
  logic    is_master;
  logic    is_slave;
  logic    on;
  logic    eval;
  logic [4:0] discrimination_delay_setting_eff;

  // Word decode shared by the read and write paths
  function automatic logic [1:0] reg_sel(input logic [7:0] addr);
    logic [1:0] sel;
    sel = 2'h0;
    if (addr[7:2] == pilot_sup_pkg::CTRL_OFS[7:2]) begin
      sel = 2'h1;
    end else if (addr[7:2] == pilot_sup_pkg::DELAY_OFS[7:2]) begin
      sel = 2'h2;
    end else if (addr[7:2] == pilot_sup_pkg::STATUS_OFS[7:2]) begin
      sel = 2'h3;
    end
    return sel;
  endfunction : reg_sel

  tick_gen #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk  (clk),
    .rstn (rstn),
    .tick (tick)
  );

  // Only second synchroniser stage is read
  assign sense   = r_reg.sync2.pilot_sense;
  assign rst_in  = r_reg.sync2.reset_btn;
  assign init_in = r_reg.sync2.initiate;
  assign trip_in = r_reg.sync2.trip_in;

  assign is_master = r_reg.mode == pilot_sup_pkg::MODE_MASTER;
  assign is_slave  = r_reg.mode == pilot_sup_pkg::MODE_SLAVE;
  assign on        = is_master || is_slave;

  // Master judges at cycle end, slave after its gap
  assign eval = on && tick && r_reg.st == pilot_sup_pkg::ST_RUN &&
                (is_master ?
                 r_reg.phase == pilot_sup_pkg::CYCLE_TICKS - 6'h01 :
                 r_reg.phase == pilot_sup_pkg::GAP_END);

  // A zero setting still gives the shortest step
  assign discrimination_delay_setting_eff = (r_reg.discrimination_delay_setting == 5'h00) ? 5'h01 : r_reg.discrimination_delay_setting;

  always_comb begin
    r_next = r_reg;
    r_next.sync1 = pins_in;
    r_next.sync2 = r_reg.sync1;

    // Write channel: address and data in either order
    if (r_reg.rsp.awready && axi_req.awvalid) begin
      r_next.aw_ok  = 1'b1;
      r_next.awaddr = axi_req.awaddr;
    end
    if (r_reg.rsp.wready && axi_req.wvalid) begin
      r_next.w_ok  = 1'b1;
      r_next.wdata = axi_req.wdata;
      r_next.wstrb = axi_req.wstrb;
    end
    if (r_next.aw_ok && r_next.w_ok && !r_reg.rsp.bvalid) begin
      r_next.aw_ok      = 1'b0;
      r_next.w_ok       = 1'b0;
      r_next.rsp.bvalid = 1'b1;
      r_next.rsp.bresp  = (reg_sel(r_next.awaddr) == 2'h0) ?
                          pilot_sup_pkg::RESP_SLVERR :
                          pilot_sup_pkg::RESP_OKAY;
      if (r_next.wstrb[0]) begin
        if (reg_sel(r_next.awaddr) == 2'h1) begin
          r_next.mode = r_next.wdata[pilot_sup_pkg::MODE_POS +: 2];
        end
        if (reg_sel(r_next.awaddr) == 2'h2) begin
          r_next.discrimination_delay_setting = r_next.wdata[pilot_sup_pkg::DISCRIMINATION_DELAY_SETTING_POS +: 5];
        end
      end
    end else if (r_reg.rsp.bvalid && axi_req.bready) begin
      r_next.rsp.bvalid = 1'b0;
    end
    r_next.rsp.awready = !r_next.aw_ok && !r_next.rsp.bvalid;
    r_next.rsp.wready  = !r_next.w_ok && !r_next.rsp.bvalid;

    // Read channel
    if (r_reg.rsp.arready && axi_req.arvalid) begin
      r_next.rsp.rvalid = 1'b1;
      r_next.rsp.rresp  = pilot_sup_pkg::RESP_OKAY;
      r_next.rsp.rdata  = 32'h0000_0000;
      unique case (reg_sel(axi_req.araddr))
        2'h1: r_next.rsp.rdata[pilot_sup_pkg::MODE_POS +: 2] = r_reg.mode;
        2'h2: r_next.rsp.rdata[pilot_sup_pkg::DISCRIMINATION_DELAY_SETTING_POS +: 5] = r_reg.discrimination_delay_setting;
        2'h3: begin
          r_next.rsp.rdata[pilot_sup_pkg::ST_HEALTHY] =
            r_reg.po.healthy_led;
          r_next.rsp.rdata[pilot_sup_pkg::ST_ALARM]    = r_reg.alarm;
          r_next.rsp.rdata[pilot_sup_pkg::ST_TRIPOPEN] = r_reg.trip_open;
          r_next.rsp.rdata[pilot_sup_pkg::ST_DISC] = r_reg.po.disc_led;
          r_next.rsp.rdata[pilot_sup_pkg::ST_LOCK] = r_reg.lock;
          r_next.rsp.rdata[pilot_sup_pkg::ST_MISS +: 2] = r_reg.miss;
          r_next.rsp.rdata[pilot_sup_pkg::ST_FSM +: 3]  = r_reg.st;
          r_next.rsp.rdata[pilot_sup_pkg::ST_PHASE +: 6] = r_reg.phase;
        end
        2'h0: r_next.rsp.rresp = pilot_sup_pkg::RESP_SLVERR;
      endcase
    end else if (r_reg.rsp.rvalid && axi_req.rready) begin
      r_next.rsp.rvalid = 1'b0;
    end
    r_next.rsp.arready = !r_next.rsp.rvalid;

    // Supervision sequence
    if (!on) begin
      r_next.st    = pilot_sup_pkg::ST_OFF;
      r_next.phase = 6'h00;
      r_next.run   = 6'h00;
      r_next.hold  = 6'h00;
      r_next.lock  = 1'b0;
      r_next.got   = 1'b0;
      r_next.ok    = 1'b0;
      r_next.miss  = 2'h0;
      r_next.good  = 2'h0;
      r_next.alarm = 1'b0;
      r_next.dwell = 3'h0;
    end else if (r_reg.st == pilot_sup_pkg::ST_OFF) begin
      r_next.st    = is_master ? pilot_sup_pkg::ST_START :
                                 pilot_sup_pkg::ST_RUN;
      r_next.phase = 6'h00;
      r_next.run   = 6'h00;
    end else if (tick) begin
      if (r_reg.dwell != 3'h0) begin
        r_next.dwell = r_reg.dwell - 3'h1;
      end
      if (!rst_in) begin
        r_next.hold = 6'h00;
      end else if (r_reg.hold != pilot_sup_pkg::HOLD_TICKS) begin
        r_next.hold = r_reg.hold + 6'h01;
      end
      // Local reset; a lasting fault comes back later
      if (rst_in && r_reg.dwell == 3'h0) begin
        r_next.alarm = 1'b0;
        r_next.miss  = 2'h0;
        r_next.good  = 2'h0;
      end
      if (is_master && rst_in &&
          r_reg.hold == pilot_sup_pkg::HOLD_TICKS - 6'h01) begin
        r_next.st    = pilot_sup_pkg::ST_START;
        r_next.run   = 6'h00;
        r_next.alarm = 1'b0;
        r_next.miss  = 2'h0;
        r_next.good  = 2'h0;
        r_next.dwell = 3'h0;
        r_next.got   = 1'b0;
      end else begin
        unique case (r_reg.st)
          pilot_sup_pkg::ST_START: begin
            if (r_reg.run == pilot_sup_pkg::START_TICKS - 6'h01) begin
              r_next.st    = pilot_sup_pkg::ST_RUN;
              r_next.phase = pilot_sup_pkg::PULSE_TICKS;
              r_next.run   = 6'h00;
            end else begin
              r_next.run = r_reg.run + 6'h01;
            end
          end
          pilot_sup_pkg::ST_RUN: begin
            r_next.phase =
              (r_reg.phase == pilot_sup_pkg::CYCLE_TICKS - 6'h01) ?
              6'h00 : r_reg.phase + 6'h01;
            if (is_master) begin
              if (r_reg.phase == pilot_sup_pkg::SAMPLE_PH && sense) begin
                r_next.got = 1'b1;
              end
            end else if (sense && !r_reg.po.pilot_drive) begin
              if (r_reg.run != 6'h3F) begin
                r_next.run = r_reg.run + 6'h01;
              end
              // Long master pulse means a restart
              if (r_reg.run == pilot_sup_pkg::START_TICKS - 6'h01) begin
                r_next.alarm = 1'b0;
                r_next.miss  = 2'h0;
                r_next.good  = 2'h0;
                r_next.dwell = 3'h0;
              end
            end else begin
              // Relock on each master pulse end after at least LOCK_MIN ticks of pulse
              if (!sense && r_reg.run >= pilot_sup_pkg::LOCK_MIN) begin
                r_next.phase = pilot_sup_pkg::PULSE_TICKS;
                r_next.lock  = 1'b1;
                r_next.got   = 1'b1;
              end
              r_next.run = 6'h00;
            end
          end
          default: ;
        endcase
      end
    end

    // Once per cycle: count misses or good cycles
    if (eval) begin
      r_next.got = 1'b0;
      if (r_next.got || r_reg.got) begin
        r_next.miss = 2'h0;
        r_next.ok   = 1'b1;
        if (r_reg.alarm) begin
          if (r_reg.good == pilot_sup_pkg::GOOD_LIMIT - 2'h1) begin
            if (r_reg.dwell == 3'h0) begin
              r_next.alarm = 1'b0;
              r_next.good  = 2'h0;
            end
          end else begin
            r_next.good = r_reg.good + 2'h1;
          end
        end
      end else begin
        r_next.ok   = 1'b0;
        r_next.good = 2'h0;
        // Cycle-sized steps give the 8 to 12 s disturbance margin
        if (r_reg.miss == pilot_sup_pkg::MISS_LIMIT - 2'h1) begin
          if (!r_reg.alarm) begin
            r_next.alarm = 1'b1;
            r_next.dwell = pilot_sup_pkg::DWELL_TICKS;
          end
        end else begin
          r_next.miss = r_reg.miss + 2'h1;
        end
      end
    end

    // Trip path and discrimination timer
    if (!(on && r_next.alarm)) begin
      r_next.trip_open = 1'b0;
      r_next.done      = 1'b0;
      r_next.disc      = 5'h00;
    end else if (!r_reg.done) begin
      r_next.trip_open = 1'b1;
      if (!init_in) begin
        r_next.disc = 5'h00;
      end else if (tick) begin
        if (r_reg.disc >= discrimination_delay_setting_eff - 5'h01) begin
          r_next.done      = 1'b1;
          r_next.trip_open = 1'b0;
          r_next.disc      = 5'h00;
        end else begin
          r_next.disc = r_reg.disc + 5'h01;
        end
      end
    end

    // Pins, all registered
    r_next.po.pilot_drive = on &&
      (r_next.st == pilot_sup_pkg::ST_START ||
       (r_next.st == pilot_sup_pkg::ST_RUN &&
        (is_master ? r_next.phase < pilot_sup_pkg::PULSE_TICKS :
         (r_next.lock &&
          r_next.phase >= 6'h02 * pilot_sup_pkg::PULSE_TICKS &&
          r_next.phase < 6'h03 * pilot_sup_pkg::PULSE_TICKS))));
    r_next.po.healthy_led   = on && !r_next.alarm && r_next.ok;
    r_next.po.alarm_led     = on && r_next.alarm;
    r_next.po.alarm_contact = on && r_next.alarm;
    r_next.po.trip_out      = trip_in && !r_next.trip_open;
    r_next.po.disc_led      = on && r_next.alarm && !r_next.done &&
                              init_in;
    r_next.po.activity_led  = r_next.po.pilot_drive;
  end

  // Async reset loads constants only; mode starts off
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r_reg       <= '0;
      r_reg.st    <= pilot_sup_pkg::ST_OFF;
      r_reg.mode  <= pilot_sup_pkg::MODE_RST;
      r_reg.discrimination_delay_setting  <= pilot_sup_pkg::DISCRIMINATION_DELAY_SETTING_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign axi_rsp  = r_reg.rsp;
  assign pins_out = r_reg.po;

endmodule : pilot_sup

// ===== tb/pilot_sup_assertions.sv
`timescale 1ns/1ns
module pilot_sup_assertions #(
  parameter int unsigned TICK_CYCLES = 4
) (
  // Clock and reset
  input wire logic                     clk,
  input wire logic                     rstn,
  // Register bus
  input wire pilot_sup_pkg::axi_req_t  axi_req,
  input wire pilot_sup_pkg::axi_rsp_t  axi_rsp,
  // Pins
  input wire pilot_sup_pkg::pins_in_t  pins_in,
  input wire pilot_sup_pkg::pins_out_t pins_out
);
  int unsigned hi_cnt;
  int unsigned dw_cnt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Run lengths, too long to unroll as repetitions
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hi_cnt <= 0;
      dw_cnt <= 0;
    end else begin
      hi_cnt <= pins_out.pilot_drive ? hi_cnt + 1 : 0;
      dw_cnt <= pins_out.alarm_contact ? dw_cnt + 1 : 0;
    end
  end

  sequence drive_rise;
    $rose(pins_out.pilot_drive);
  endsequence
  sequence drive_fall;
    $fell(pins_out.pilot_drive);
  endsequence

  drive_min_a: assert property (
    drive_rise |=> pins_out.pilot_drive [*8])
    else $error("pilot pulse too short");
  gap_min_a: assert property (
    drive_fall |=> !pins_out.pilot_drive [*8])
    else $error("pilot gap too short");
  drive_max_a: assert property (
    hi_cnt <= 21 * TICK_CYCLES)
    else $error("pilot pulse too long");
  trip_pass_a: assert property (
    !pins_out.alarm_led [*4] |-> pins_out.trip_out == $past(pins_in.trip_in, 3))
    else $error("trip not passed while healthy");
  trip_block_a: assert property (
    $rose(pins_out.alarm_led) |=> !pins_out.trip_out)
    else $error("trip path not opened on alarm");
  disc_trip_a: assert property (
    pins_out.disc_led |-> !pins_out.trip_out)
    else $error("trip passed while delay running");
  init_drop_a: assert property (
    $fell(pins_in.initiate) |-> ##[1:4] !pins_out.disc_led)
    else $error("delay lamp stays after initiate drop");
  init_need_a: assert property (
    !pins_in.initiate [*5] |-> !pins_out.disc_led)
    else $error("delay runs without initiate");
  dwell_min_a: assert property (
    $fell(pins_out.alarm_contact) |-> dw_cnt >= 4 * TICK_CYCLES)
    else $error("alarm contact dwell too short");
  contact_set_a: assert property (
    $rose(pins_out.alarm_led) |-> ##[0:1] pins_out.alarm_contact)
    else $error("alarm contact not set");
endmodule : pilot_sup_assertions

bind pilot_sup pilot_sup_assertions #(.TICK_CYCLES(TICK_CYCLES))
  i_pilot_sup_assertions (.clk(clk), .rstn(rstn), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .pins_in(pins_in), .pins_out(pins_out));

// ===== tb/pilot_remote_station.sv
`timescale 1ns/1ns
module pilot_remote_station #(
  parameter int unsigned T = 4
) (
  // Clock
  input  wire logic clk,
  // Pilot
  input  wire logic line_in,
  input  wire logic mute,
  output logic      line_out
);
  int hi;

  // Pull-down on the pair: released line reads low
  initial line_out = 1'h0;

  always @(posedge clk) begin
    hi <= line_in ? hi + 1 : 0;
  end

  // Answer a long enough master pulse after a gap; mute models a dead end
  always @(negedge line_in) begin
    if (!mute && hi >= 8 * T) begin
      repeat (10 * T) @(posedge clk);
      line_out <= 1'h1;
      repeat (10 * T) @(posedge clk);
      line_out <= 1'h0;
    end
  end
endmodule : pilot_remote_station

// ===== tb/pilot_sup_tb.sv
`timescale 1ns/1ns
module pilot_sup_tb;
  localparam int unsigned T   = 4;
  localparam int unsigned CYC = 40 * T;
  logic                     clk;
  logic                     rstn;
  logic                     mute;
  logic                     init_r;
  logic                     trip_r;
  logic                     rbtn_r;
  logic                     line_far;
  logic [1:0]               r;
  int                       fails;
  int                       compares;
  pilot_sup_pkg::axi_req_t  axi_req;
  pilot_sup_pkg::axi_rsp_t  axi_rsp;
  pilot_sup_pkg::pins_in_t  pins_in;
  pilot_sup_pkg::pins_out_t pins_out;
  pilot_sup_pkg::axi_rsp_t  rsp_s;
  pilot_sup_pkg::pins_out_t po_s;

  // Shared pair: either end driving shows as pilot voltage
  assign pins_in = '{pins_out.pilot_drive | line_far, rbtn_r, init_r, trip_r};

  pilot_sup #(.TICK_CYCLES(T)) i_pilot_sup (.clk(clk), .rstn(rstn),
    .axi_req(axi_req), .axi_rsp(axi_rsp), .pins_in(pins_in),
    .pins_out(pins_out));
  pilot_remote_station #(.T(T)) i_pilot_remote_station (.clk(clk),
    .line_in(pins_out.pilot_drive), .mute(mute), .line_out(line_far));

  always #25 clk = ~clk;

  // Settled mid-cycle, so after an edge these are its sampled values
  always @(negedge clk) begin
    rsp_s <= axi_rsp;
    po_s  <= pins_out;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("Compares %0d, fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'h0;
    w_done = 1'h0;
    @(posedge clk);
    axi_req.awvalid <= 1'h1;
    axi_req.awaddr  <= a;
    axi_req.wvalid  <= 1'h1;
    axi_req.wdata   <= d;
    axi_req.bready  <= 1'h1;
    forever begin
      @(posedge clk);
      if (rsp_s.awready && !aw_done) begin
        aw_done = 1'h1;
        axi_req.awvalid <= 1'h0;
      end
      if (rsp_s.wready && !w_done) begin
        w_done = 1'h1;
        axi_req.wvalid <= 1'h0;
      end
      if (rsp_s.bvalid) break;
    end
    r = rsp_s.bresp;
    axi_req.bready <= 1'h0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    axi_req.arvalid <= 1'h1;
    axi_req.araddr  <= a;
    axi_req.rready  <= 1'h1;
    do begin
      @(posedge clk);
      if (rsp_s.arready && axi_req.arvalid) axi_req.arvalid <= 1'h0;
    end while (!rsp_s.rvalid);
    d = rsp_s.rdata;
    r = rsp_s.rresp;
    axi_req.rready <= 1'h0;
  endtask : axi_read

  task automatic wait_pin(input int b, input logic v, input int lim,
                          output int n);
    n = 0;
    while (po_s[b] !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_pin

  task automatic reg_test;
    logic [31:0] d;
    axi_read(8'h00, d);
    check(d, 32'h0);
    axi_read(8'h04, d);
    check(d, 32'h1);
    axi_read(8'h0C, d);
    check({d[29:0], r}, 32'h2);
    axi_write(8'h04, 32'h1F);
    axi_read(8'h04, d);
    check(d, 32'h1F);
    $display("reg_test done");
  endtask : reg_test

  task automatic slave_test;
    int n;
    logic drv;
    n = 0;
    drv = 1'h0;
    axi_write(8'h00, 32'h2);
    while (po_s.alarm_led !== 1'h1 && n < 6 * CYC) begin
      @(posedge clk);
      n++;
      drv = drv | po_s.pilot_drive;
    end
    check(po_s.alarm_led, 1'h1);
    check(drv, 1'h0);
    repeat (8 * T) @(posedge clk);
    axi_write(8'h00, 32'h0);
    repeat (4) @(posedge clk);
    check({po_s.healthy_led, po_s.alarm_led,
           po_s.alarm_contact}, 32'h0);
    $display("slave_test done");
  endtask : slave_test

  task automatic master_test;
    int n;
    axi_write(8'h00, 32'h1);
    wait_pin(6, 1'h1, 10, n);
    check({po_s.pilot_drive, po_s.activity_led}, 32'h3);
    wait_pin(6, 1'h0, 30 * T, n);
    check(32'(n >= 19 * T && n <= 21 * T), 32'h1);
    wait_pin(5, 1'h1, 2 * CYC, n);
    check(po_s.healthy_led, 1'h1);
    trip_r <= 1'h1;
    repeat (5) @(posedge clk);
    check(po_s.trip_out, 1'h1);
    $display("master_test done");
  endtask : master_test

  task automatic miss_test;
    int n;
    mute <= 1'h1;
    repeat (CYC) @(posedge clk);
    mute <= 1'h0;
    wait_pin(4, 1'h1, 3 * CYC, n);
    check(po_s.alarm_led, 1'h0);
    check(po_s.healthy_led, 1'h1);
    $display("miss_test done");
  endtask : miss_test

  task automatic alarm_test;
    int n;
    axi_write(8'h04, 32'h14);
    mute <= 1'h1;
    wait_pin(4, 1'h1, 6 * CYC, n);
    check(32'(n >= 2 * CYC), 32'h1);
    check(po_s.alarm_contact, 1'h1);
    repeat (3) @(posedge clk);
    check(po_s.trip_out, 1'h0);
    init_r <= 1'h1;
    repeat (10 * T) @(posedge clk);
    check(po_s.disc_led, 1'h1);
    init_r <= 1'h0;
    repeat (5) @(posedge clk);
    check({po_s.disc_led, po_s.trip_out}, 32'h0);
    init_r <= 1'h1;
    wait_pin(2, 1'h1, 30 * T, n);
    check(32'(n >= 19 * T && n <= 20 * T + 6), 32'h1);
    check(po_s.disc_led, 1'h0);
    $display("alarm_test done");
  endtask : alarm_test

  task automatic recover_test;
    int n;
    init_r <= 1'h0;
    mute <= 1'h0;
    wait_pin(4, 1'h0, 6 * CYC, n);
    check(32'(n >= CYC && po_s.alarm_led === 1'h0), 32'h1);
    repeat (5) @(posedge clk);
    check(po_s.trip_out, 1'h1);
    $display("recover_test done");
  endtask : recover_test

  // Hold starts just after a pulse end so the restart lands in the gap
  task automatic restart_test;
    int n;
    logic [31:0] d;
    wait_pin(6, 1'h1, 2 * CYC, n);
    wait_pin(6, 1'h0, 2 * CYC, n);
    rbtn_r <= 1'h1;
    repeat (22 * T) @(posedge clk);
    axi_read(8'h08, d);
    check(32'(d[14:12]), 32'h2);
    rbtn_r <= 1'h0;
    check(po_s.pilot_drive, 1'h1);
    $display("restart_test done");
  endtask : restart_test

  initial begin
    clk = 1'h0;
    rstn = 1'h0;
    axi_req = '0;
    axi_req.wstrb = 4'hF;
    mute = 1'h0;
    init_r = 1'h0;
    trip_r = 1'h0;
    rbtn_r = 1'h0;
    fails = 0;
    compares = 0;
    repeat (8) @(posedge clk);
    rstn <= 1'h1;
    repeat (2) @(posedge clk);
    reg_test();
    slave_test();
    master_test();
    miss_test();
    alarm_test();
    recover_test();
    restart_test();
    finish_test();
  end

  // Whole run is about 15 supervision cycles; allow ample margin
  initial begin
    repeat (150 * CYC) @(posedge clk);
    fails++;
    finish_test();
  end
endmodule : pilot_sup_tb
